// >>> design/scif_top.sv
// serial interface receiver flags, control one, pin takeover, apb slave
// assumes: apb master on mclk; serial_in_pin is asynchronous to mclk
//
// The placing of the registers and register access over APB were left to the implementer.
`include "scif_map.svh"
module scif_top
  import scif_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  output logic             serial_out_oe,
  output logic             serial_in_oe,
  output logic             rx_irq,
  output logic             err_irq,
  output logic             tx_irq
);
  // register state
  logic [7:0]  ctrl1_ff, nxt_ctrl1, ctrl2_ff, nxt_ctrl2, ctrl3_ff, nxt_ctrl3;
  logic [7:0]  stat1_ff, nxt_stat1, data_ff, nxt_data, baud_ff, nxt_baud;
  logic [7:0]  txd_ff, nxt_txd;
  logic [5:0]  sys_ff, nxt_sys;
  logic        rd_stat_ff, nxt_rd_stat;
  logic [31:0] prdata_ff, nxt_prdata;
  logic        pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
  // receiver state
  scif_state_t st_ff, nxt_st;
  logic [3:0]  rt_ff, nxt_rt, bit_ff, nxt_bit, ones_ff, nxt_ones;
  logic [8:0]  sh_ff, nxt_sh;
  logic [2:0]  smp_ff, nxt_smp;
  logic        nz_ff, nxt_nz, par_ff, nxt_par, idl_arm_ff, nxt_idl_arm;
  logic [7:0]  div_ff, nxt_div;
  // pin and output flops
  logic        sync1_ff, sync2_ff;
  logic        txo_ff, nxt_txo, oe_ff, nxt_oe, ioe_ff, nxt_ioe;
  logic        rxi_ff, nxt_rxi, eri_ff, nxt_eri, txi_ff, nxt_txi;
  logic        tx_line;

  // majority and noise of three samples
  function automatic logic [1:0] scif_vote(input logic [2:0] s);
    scif_vote = {(s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]),
                 (s != 3'h0) && (s != 3'h7)};
  endfunction : scif_vote

  // mapped word offsets; anything else answers with an error
  function automatic logic scif_hit(input logic [11:0] a);
    scif_hit = (a <= `SCIF_OFS_SYS) && (a[1:0] == 2'h0);
  endfunction : scif_hit

  // two-flop synchroniser for the asynchronous receive pin
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync1_ff <= 1'h1;
      sync2_ff <= 1'h1;
    end else begin
      sync1_ff <= serial_in_pin;
      sync2_ff <= sync1_ff;
    end
  end

  // decoded modes and the receive source
  logic en, brk, wt, stp, loop_on, rx_bit, len9, rx_go, acc, done, wr, rd;
  logic [3:0] nbits;
  logic [1:0] vt;
  assign en      = ctrl1_ff[`SCIF_C1_EN];
  assign brk     = sys_ff[`SCIF_SY_BRK];
  assign wt      = sys_ff[`SCIF_SY_WAIT];
  assign stp     = sys_ff[`SCIF_SY_STOP];
  // loopback only with tx and rx both enabled
  assign loop_on = ctrl1_ff[`SCIF_C1_LOOP] & ctrl2_ff[`SCIF_C2_TE]
                   & ctrl2_ff[`SCIF_C2_RE];
  assign tx_line = 1'h1 ^ ctrl1_ff[`SCIF_C1_TX_POLARITY_INVERT];  // idle level
  assign rx_bit  = loop_on ? tx_line : sync2_ff;
  assign len9    = ctrl1_ff[`SCIF_C1_LEN9];
  assign nbits   = len9 ? 4'h9 : 4'h8;
  // stop freezes the receiver and baud divider; module enable gates the logic
  assign rx_go   = en & ~stp & ctrl2_ff[`SCIF_C2_RE] & (div_ff == 8'h00);
  assign acc     = psel & penable & ~pready_ff;
  // writes and read side effects land on the edge that ends the access
  assign done    = psel & penable & pready_ff;
  assign wr      = done & pwrite & ~wt;  // registers locked in wait
  assign rd      = done & ~pwrite & ~wt;
  assign vt      = scif_vote(smp_ff);

  // receiver: 16 rt ticks per bit, samples at rt 7, 8, 9
  logic ev_full, ev_idle, ev_nz, ev_fe, ev_pe, ev_wake;
  logic [8:0] ch;
  always_comb begin
    nxt_st = st_ff;  nxt_rt = rt_ff;  nxt_bit = bit_ff;  nxt_sh = sh_ff;
    nxt_smp = smp_ff;  nxt_nz = nz_ff;  nxt_par = par_ff;
    nxt_ones = ones_ff;  nxt_idl_arm = idl_arm_ff;
    nxt_div = div_ff;
    ev_full = 1'h0;  ev_idle = 1'h0;  ev_nz = 1'h0;  ev_fe = 1'h0;
    ev_pe = 1'h0;  ev_wake = 1'h0;  ch = sh_ff;
    if (en & ~stp) begin
      nxt_div = (div_ff >= baud_ff) ? 8'h00 : div_ff + 8'h01;
    end
    if (rx_go) begin
      nxt_rt = rt_ff + 4'h1;
      if (rt_ff >= 4'h7 && rt_ff <= 4'h9) begin
        nxt_smp = {smp_ff[1:0], rx_bit};
      end
      // idle counter: ones in a row, one per bit time
      if (rt_ff == `SCIF_RT_PER_BIT) begin
        if (idl_arm_ff && rx_bit && ones_ff < nbits + 4'h2) begin
          nxt_ones = ones_ff + 4'h1;
        end else if (!rx_bit) begin
          nxt_ones = 4'h0;
        end
        if (idl_arm_ff && ones_ff == nbits + 4'h1 && rx_bit) begin
          ev_idle = 1'h1;
          nxt_idl_arm = 1'h0;
        end
      end
      case (st_ff)
        SCIF_IDLE: begin
          // bit timer runs on so an idle line keeps counting ones
          if (!rx_bit) begin
            nxt_rt = 4'h0;
            nxt_st = SCIF_START;
            nxt_nz = 1'h0;
            nxt_par = 1'h0;
            nxt_bit = 4'h0;
          end
        end
        SCIF_START: begin
          if (rt_ff == `SCIF_RT_PER_BIT) begin
            if (vt[1]) begin
              nxt_st = SCIF_IDLE;  // false start
            end else begin
              nxt_st = SCIF_DATA;
              nxt_nz = nz_ff | vt[0];
              if (!ctrl1_ff[`SCIF_C1_IDLE_COUNT_START_SEL]) begin
                nxt_idl_arm = 1'h1;   // count after start bit
                nxt_ones = 4'h0;
              end
            end
          end
        end
        SCIF_DATA: begin
          if (rt_ff == `SCIF_RT_PER_BIT) begin
            nxt_sh = {vt[1], sh_ff[8:1]};
            nxt_par = par_ff ^ vt[1];
            nxt_nz = nz_ff | vt[0];
            nxt_bit = bit_ff + 4'h1;
            if (bit_ff == nbits - 4'h1) begin
              nxt_st = SCIF_STOP;
            end
          end
        end
        SCIF_STOP: begin
          if (rt_ff == `SCIF_RT_PER_BIT) begin
            nxt_st = SCIF_IDLE;
            ch = len9 ? sh_ff : {1'h0, sh_ff[8:1]};
            ev_full = 1'h1;
            ev_nz = nz_ff | vt[0];
            ev_fe = ~vt[1];
            // odd type expects odd count of ones
            ev_pe = ctrl1_ff[`SCIF_C1_PEN]
                    & (par_ff ^ ctrl1_ff[`SCIF_C1_PODD]);
            ev_wake = ctrl1_ff[`SCIF_C1_WAKE] & ch[nbits - 4'h1];
            if (ctrl1_ff[`SCIF_C1_IDLE_COUNT_START_SEL]) begin
              nxt_idl_arm = 1'h1;  // count after stop bit
              nxt_ones = 4'h0;
            end
          end
        end
        default: nxt_st = SCIF_IDLE;
      endcase
    end else if (!en) begin
      nxt_st = SCIF_IDLE;
      nxt_rt = 4'h0;
    end
  end

  // receiver flops
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_ff <= SCIF_IDLE;  rt_ff <= 4'h0;  bit_ff <= 4'h0;
      sh_ff <= 9'h000;  smp_ff <= 3'h7;  nz_ff <= 1'h0;  par_ff <= 1'h0;
      ones_ff <= 4'h0;  idl_arm_ff <= 1'h0;  div_ff <= 8'h00;
    end else begin
      st_ff <= nxt_st;  rt_ff <= nxt_rt;  bit_ff <= nxt_bit;
      sh_ff <= nxt_sh;  smp_ff <= nxt_smp;  nz_ff <= nxt_nz;
      par_ff <= nxt_par;  ones_ff <= nxt_ones;
      idl_arm_ff <= nxt_idl_arm;  div_ff <= nxt_div;
    end
  end

  // registers, flags and the apb answer; set wins over clear
  logic clr_ok, stby, pen_msb;
  always_comb begin
    nxt_ctrl1 = ctrl1_ff;  nxt_ctrl2 = ctrl2_ff;  nxt_ctrl3 = ctrl3_ff;
    nxt_stat1 = stat1_ff;  nxt_data = data_ff;  nxt_baud = baud_ff;
    nxt_txd = txd_ff;  nxt_sys = sys_ff;  nxt_rd_stat = rd_stat_ff;
    nxt_prdata = prdata_ff;
    nxt_pslverr = acc & ~scif_hit(paddr);  // error answers with pready
    nxt_pready = acc;
    clr_ok = ~brk | sys_ff[`SCIF_SY_BREAK_CLEAR_ENABLE];
    stby = ctrl2_ff[`SCIF_C2_RWU];
    pen_msb = 1'h0;
    // two-step clear: status read then data read clears rx flags
    if (rd && paddr == `SCIF_OFS_STAT1 && clr_ok) begin
      nxt_rd_stat = 1'h1;                     // armed only outside break or with break clear enabled
    end
    if (rd && paddr == `SCIF_OFS_DATA && rd_stat_ff && clr_ok) begin
      nxt_stat1[`SCIF_S1_RF:`SCIF_S1_PE] = 6'h00;
      nxt_rd_stat = 1'h0;
    end
    if (wr && paddr == `SCIF_OFS_DATA && rd_stat_ff && clr_ok) begin
      nxt_stat1[`SCIF_S1_TE] = 1'h0;
      nxt_stat1[`SCIF_S1_TC] = 1'h0;
      nxt_txd = pwdata[7:0];
    end
    if (wr) begin
      case (paddr)
        `SCIF_OFS_CTRL1: nxt_ctrl1 = pwdata[7:0];
        `SCIF_OFS_CTRL2: begin
          nxt_ctrl2 = pwdata[7:0];
          if (!en) begin  // te and re locked while disabled
            nxt_ctrl2[`SCIF_C2_TE] = ctrl2_ff[`SCIF_C2_TE];
            nxt_ctrl2[`SCIF_C2_RE] = ctrl2_ff[`SCIF_C2_RE];
          end
        end
        `SCIF_OFS_CTRL3: nxt_ctrl3 = {ctrl3_ff[7], pwdata[6:0]};
        `SCIF_OFS_BAUD:  nxt_baud = pwdata[7:0];
        `SCIF_OFS_DATA:  nxt_txd = pwdata[7:0];
        `SCIF_OFS_STAT1: ;
        `SCIF_OFS_SYS:   nxt_sys = pwdata[5:0];
        default:         ;
      endcase
    end
    if (acc & ~pwrite) begin
      case (paddr)
        `SCIF_OFS_CTRL1: nxt_prdata = {24'h000000, ctrl1_ff};
        `SCIF_OFS_CTRL2: nxt_prdata = {24'h000000, ctrl2_ff};
        `SCIF_OFS_CTRL3: nxt_prdata = {24'h000000, ctrl3_ff};
        `SCIF_OFS_STAT1: nxt_prdata = {24'h000000, stat1_ff};
        `SCIF_OFS_DATA:  nxt_prdata = {24'h000000, data_ff};
        `SCIF_OFS_BAUD:  nxt_prdata = {24'h000000, baud_ff};
        `SCIF_OFS_SYS:   nxt_prdata = {26'h0000000, sys_ff};
        default:         nxt_prdata = 32'h00000000;
      endcase
      if (wt) begin
        nxt_prdata = 32'h00000000;  // unreachable in wait
      end
    end
    // disabled module forces tx empty and complete
    if (!en) begin
      nxt_stat1[`SCIF_S1_TE] = 1'h1;
      nxt_stat1[`SCIF_S1_TC] = 1'h1;
      nxt_ctrl2[`SCIF_C2_TEIE] = 1'h0;
      nxt_ctrl2[`SCIF_C2_TCIE] = 1'h0;
    end
    // receiver events; standby hides characters
    if (ev_idle) begin
      if (stby && !ctrl1_ff[`SCIF_C1_WAKE]) begin
        nxt_ctrl2[`SCIF_C2_RWU] = 1'h0;  // idle-line wakeup
      end else if (!stby) begin
        nxt_stat1[`SCIF_S1_IDLE] = 1'h1;
      end
    end
    if (ev_full && (!stby || ev_wake)) begin
      if (ev_wake) begin
        nxt_ctrl2[`SCIF_C2_RWU] = 1'h0;  // address mark wakeup
      end
      if (stat1_ff[`SCIF_S1_RF] && nxt_stat1[`SCIF_S1_RF]) begin
        nxt_stat1[`SCIF_S1_OR] = 1'h1;  // old character kept
      end else begin
        pen_msb = ctrl1_ff[`SCIF_C1_PEN];
        nxt_data = ch[7:0];
        if (pen_msb && !len9) begin
          nxt_data[7] = 1'h0;  // parity sits in the top bit
        end
        nxt_ctrl3[`SCIF_C3_R8] = len9 ? ch[8] : ch[7];
        nxt_stat1[`SCIF_S1_RF] = 1'h1;
        nxt_stat1[`SCIF_S1_NF] = nxt_stat1[`SCIF_S1_NF] | ev_nz;
        nxt_stat1[`SCIF_S1_FE] = nxt_stat1[`SCIF_S1_FE] | ev_fe;
        nxt_stat1[`SCIF_S1_PE] = nxt_stat1[`SCIF_S1_PE] | ev_pe;
      end
    end
  end

  // outputs: pins and requests, all registered
  always_comb begin
    nxt_txo = en ? tx_line : 1'h1;
    nxt_oe  = en | sys_ff[`SCIF_SY_DDR_TX];
    nxt_ioe = ~en & sys_ff[`SCIF_SY_DDR_RX];
    // requests also serve as wakeup from wait
    nxt_rxi = ~ctrl2_ff[`SCIF_C2_RWU]
              & ((stat1_ff[`SCIF_S1_RF] & ctrl2_ff[`SCIF_C2_RIE])
              | (stat1_ff[`SCIF_S1_IDLE] & ctrl2_ff[`SCIF_C2_IDLE_INT_EN]));
    nxt_eri = (stat1_ff[`SCIF_S1_OR] & ctrl3_ff[`SCIF_C3_OVERRUN_INT_EN])
              | (stat1_ff[`SCIF_S1_NF] & ctrl3_ff[`SCIF_C3_NOISE_INT_EN])
              | (stat1_ff[`SCIF_S1_FE] & ctrl3_ff[`SCIF_C3_FRAMING_INT_EN])
              | (stat1_ff[`SCIF_S1_PE] & ctrl3_ff[`SCIF_C3_PARITY_INT_EN]);
    nxt_txi = en & ((stat1_ff[`SCIF_S1_TE] & ctrl2_ff[`SCIF_C2_TEIE])
              | (stat1_ff[`SCIF_S1_TC] & ctrl2_ff[`SCIF_C2_TCIE]));
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl1_ff <= `SCIF_RST_CTRL;  ctrl2_ff <= `SCIF_RST_CTRL;
      ctrl3_ff <= `SCIF_RST_CTRL;  stat1_ff <= `SCIF_RST_STAT1;
      data_ff <= 8'h00;  baud_ff <= `SCIF_RST_BAUD;  txd_ff <= 8'h00;
      sys_ff <= 6'h00;  rd_stat_ff <= 1'h0;  prdata_ff <= 32'h00000000;
      pready_ff <= 1'h0;  pslverr_ff <= 1'h0;
      txo_ff <= 1'h1;  oe_ff <= 1'h0;  ioe_ff <= 1'h0;
      rxi_ff <= 1'h0;  eri_ff <= 1'h0;  txi_ff <= 1'h0;
    end else begin
      ctrl1_ff <= nxt_ctrl1;  ctrl2_ff <= nxt_ctrl2;  ctrl3_ff <= nxt_ctrl3;
      stat1_ff <= nxt_stat1;  data_ff <= nxt_data;  baud_ff <= nxt_baud;
      txd_ff <= nxt_txd;  sys_ff <= nxt_sys;  rd_stat_ff <= nxt_rd_stat;
      prdata_ff <= nxt_prdata;  pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      txo_ff <= nxt_txo;  oe_ff <= nxt_oe;  ioe_ff <= nxt_ioe;
      rxi_ff <= nxt_rxi;  eri_ff <= nxt_eri;  txi_ff <= nxt_txi;
    end
  end

  assign prdata         = prdata_ff;
  assign pready         = pready_ff;
  assign pslverr        = pslverr_ff;
  assign serial_out_pin = txo_ff;
  assign serial_out_oe  = oe_ff;
  assign serial_in_oe   = ioe_ff;
  assign rx_irq         = rxi_ff;
  assign err_irq        = eri_ff;
  assign tx_irq         = txi_ff;

  // checks
  chk_err_gate: assert property (@(posedge mclk) disable iff (!rst_n)
    (stat1_ff[`SCIF_S1_OR] && !ctrl3_ff[`SCIF_C3_NOISE_INT_EN]
     && !ctrl3_ff[`SCIF_C3_FRAMING_INT_EN] && !ctrl3_ff[`SCIF_C3_PARITY_INT_EN])
    |=> (err_irq == $past(ctrl3_ff[`SCIF_C3_OVERRUN_INT_EN])))
    else $error("overrun request not gated by its enable");
  chk_disable_flags: assert property (@(posedge mclk) disable iff (!rst_n)
    !en |=> stat1_ff[`SCIF_S1_TE] && stat1_ff[`SCIF_S1_TC])
    else $error("tx flags not set while disabled");
  chk_pin_dir: assert property (@(posedge mclk) disable iff (!rst_n)
    en |=> serial_out_oe && !serial_in_oe)
    else $error("pins not taken over while enabled");
  chk_overrun_keep: assert property (@(posedge mclk) disable iff (!rst_n)
    stat1_ff[`SCIF_S1_RF] && !rd |=> $stable(data_ff))
    else $error("data register overwritten while full");
  chk_break_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    brk && !sys_ff[`SCIF_SY_BREAK_CLEAR_ENABLE] && stat1_ff[`SCIF_S1_RF]
    |=> stat1_ff[`SCIF_S1_RF])
    else $error("flag cleared during protected break");
  chk_apb_ready: assert property (@(posedge mclk) disable iff (!rst_n)
    psel && penable && !pready |=> pready)
    else $error("apb access not answered in one cycle");
  chk_tx_invert: assert property (@(posedge mclk) disable iff (!rst_n)
    en && $stable(ctrl1_ff) |=>
    serial_out_pin == !$past(ctrl1_ff[`SCIF_C1_TX_POLARITY_INVERT]))
    else $error("transmit idle level polarity wrong");
  chk_wait_lock: assert property (@(posedge mclk) disable iff (!rst_n)
    wt && done && pwrite |=> $stable(ctrl1_ff))
    else $error("register written during wait");
endmodule : scif_top

// >>> design/scif_map.svh
// register offsets, field positions, reset values and timing counts
// assumes: included by the package, the top module and the bench
`ifndef SCIF_MAP_SVH
`define SCIF_MAP_SVH
`define SCIF_OFS_CTRL1   12'h000
`define SCIF_OFS_CTRL2   12'h004
`define SCIF_OFS_CTRL3   12'h008
`define SCIF_OFS_STAT1   12'h00c
`define SCIF_OFS_DATA    12'h010
`define SCIF_OFS_BAUD    12'h014
`define SCIF_OFS_SYS     12'h018
// control one fields
`define SCIF_C1_LOOP     7
`define SCIF_C1_EN       6
`define SCIF_C1_TX_POLARITY_INVERT    5
`define SCIF_C1_LEN9     4
`define SCIF_C1_WAKE     3
`define SCIF_C1_IDLE_COUNT_START_SEL     2
`define SCIF_C1_PEN      1
`define SCIF_C1_PODD     0
// control two fields
`define SCIF_C2_TEIE     7
`define SCIF_C2_TCIE     6
`define SCIF_C2_RIE      5
`define SCIF_C2_IDLE_INT_EN     4
`define SCIF_C2_TE       3
`define SCIF_C2_RE       2
`define SCIF_C2_RWU      1
`define SCIF_C2_SBK      0
// control three fields
`define SCIF_C3_R8       7
`define SCIF_C3_T8       6
`define SCIF_C3_OVERRUN_INT_EN     3
`define SCIF_C3_NOISE_INT_EN     2
`define SCIF_C3_FRAMING_INT_EN     1
`define SCIF_C3_PARITY_INT_EN     0
// status one fields
`define SCIF_S1_TE       7
`define SCIF_S1_TC       6
`define SCIF_S1_RF       5
`define SCIF_S1_IDLE     4
`define SCIF_S1_OR       3
`define SCIF_S1_NF       2
`define SCIF_S1_FE       1
`define SCIF_S1_PE       0
// system control fields (break, wait, stop, port direction)
`define SCIF_SY_BREAK_CLEAR_ENABLE     0
`define SCIF_SY_BRK      1
`define SCIF_SY_WAIT     2
`define SCIF_SY_STOP     3
`define SCIF_SY_DDR_TX   4
`define SCIF_SY_DDR_RX   5
`define SCIF_RST_CTRL    8'h00
`define SCIF_RST_STAT1   8'hc0
`define SCIF_RST_BAUD    8'h00
`define SCIF_RT_PER_BIT  4'hf
`endif

// >>> design/scif_pkg.sv
// types shared by the serial flag/control block
// assumes: the map header sits next to this file
`include "scif_map.svh"
package scif_pkg;
  typedef enum logic [3:0] {
    SCIF_IDLE  = 4'h1,
    SCIF_START = 4'h2,
    SCIF_DATA  = 4'h4,
    SCIF_STOP  = 4'h8
  } scif_state_t;
  typedef struct packed {
    logic       serial_out_pin;
    logic       serial_out_oe;
    logic       rx_irq;
    logic       err_irq;
    logic       tx_irq;
  } scif_pins_t;
endpackage : scif_pkg

// >>> testbench/scif_remote_tx.sv
// remote serial transmitter model that drives the receive pin
// assumes: bench clock mclk, one bit lasts BIT_CLKS mclk cycles
module scif_remote_tx #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic mclk,
  output logic      line
);
  timeunit 1ns;
  timeprecision 1ps;

  // the line idles high between frames
  initial line = 1'b1;

  // start bit, n bits lsb first, stop bit; an optional one-cycle
  // glitch in the middle of bit "noisy" (start bit is index 0)
  task automatic send(input logic [9:0] bits, input int n,
                      input logic stp, input int noisy);
    logic lvl;
    for (int i = 0; i <= n + 1; i++) begin
      lvl = (i == 0) ? 1'b0 : (i > n) ? stp : bits[i-1];
      for (int c = 0; c < BIT_CLKS; c++) begin
        @(posedge mclk);
        line <= (i == noisy && c == 8) ? ~lvl : lvl;
      end
    end
    // a bad stop level is never left standing on the line
    @(posedge mclk);
    line <= 1'b1;
  endtask : send
endmodule : scif_remote_tx

// >>> testbench/tb.sv
// self-checking bench for the serial flag and control block
// assumes: design and remote model compiled first, apb on mclk
`include "scif_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] C1 = `SCIF_OFS_CTRL1;
  localparam logic [11:0] C2 = `SCIF_OFS_CTRL2;
  localparam logic [11:0] C3 = `SCIF_OFS_CTRL3;
  localparam logic [11:0] ST = `SCIF_OFS_STAT1;
  localparam logic [11:0] DR = `SCIF_OFS_DATA;
  localparam logic [11:0] SY = `SCIF_OFS_SYS;
  logic        mclk, rst_n, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, pins;
  logic        pready, pslverr, perr, rxd, txd, tx_oe, rx_oe;
  logic        rx_irq, err_irq, tx_irq;
  int          miscompares, comparisons;

  // pin ownership view: {level, tx drive, rx drive}
  assign pins = {29'h0, txd, tx_oe, rx_oe};

  scif_top dut (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_in_pin(rxd),
    .serial_out_pin(txd), .serial_out_oe(tx_oe), .serial_in_oe(rx_oe),
    .rx_irq(rx_irq), .err_irq(err_irq), .tx_irq(tx_irq)
  );
  scif_remote_tx #(.BIT_CLKS(16)) u_rx (.mclk(mclk), .line(rxd));

  // 25 mhz bench clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  // a hang ends the run as a failure
  initial begin
    #2000000;
    miscompares++;
    close_out();
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // one apb transfer; the request stands until pready is sampled
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) miscompares++;
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q);
  endtask : wr

  task automatic rdm(input logic [11:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask : rdm

  // registered outputs need two edges to show a write
  task automatic hold();
    repeat (2) @(posedge mclk);
  endtask : hold

  task automatic rx(input logic [9:0] b, input int n, input logic s,
                    input int nz);
    u_rx.send(b, n, s, nz);
    repeat (8) @(posedge mclk);  // flag, then registered request
  endtask : rx

  // main sequence
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    rst_n = 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    // reset state, disabled pins follow direction bits
    rdm(ST, 32'hff, 32'hc0);
    rdm(C1, 32'hff, 32'h00);
    chk(pins, 32'h4);
    wr(C2, 32'h0c);
    rdm(C2, 32'hff, 32'h00);
    wr(SY, 32'h30);
    hold();
    chk(pins, 32'h7);
    wr(C1, 32'h60);
    hold();
    chk(pins, 32'h2);
    wr(SY, 32'h00);
    wr(C1, 32'h40);
    hold();
    chk(pins, 32'h6);
    // plain character, then overrun with the old data kept
    wr(C2, 32'h24);
    rx(10'h05a, 8, 1'b1, -1);
    chk({31'h0, rx_irq}, 32'h1);
    rdm(ST, 32'h2f, 32'h20);
    rdm(DR, 32'hff, 32'h5a);
    hold();
    chk({31'h0, rx_irq}, 32'h0);
    rx(10'h011, 8, 1'b1, -1);
    rx(10'h022, 8, 1'b1, -1);
    chk({31'h0, err_irq}, 32'h0);
    wr(C3, 32'h08);
    hold();
    chk({31'h0, err_irq}, 32'h1);
    rdm(ST, 32'h28, 32'h28);
    rdm(DR, 32'hff, 32'h11);
    // zero at the stop bit, then a glitch inside a data bit
    wr(C3, 32'h02);
    rx(10'h033, 8, 1'b0, -1);
    chk({31'h0, err_irq}, 32'h1);
    rdm(ST, 32'h02, 32'h02);
    rdm(DR, 32'hff, 32'h33);
    wr(C3, 32'h04);
    rx(10'h044, 8, 1'b1, 3);
    chk({31'h0, err_irq}, 32'h1);
    rdm(ST, 32'h04, 32'h04);
    rdm(DR, 32'hff, 32'h44);
    // even then odd parity, right bit then wrong bit
    wr(C3, 32'h01);
    for (int p = 0; p < 2; p++) begin
      wr(C1, 32'h42 | 32'(p));
      for (int b = 0; b < 2; b++) begin
        rx({2'b00, p[0] ^ b[0], 7'h35}, 8, 1'b1, -1);
        chk({31'h0, err_irq}, 32'(b));
        rdm(ST, 32'h01, 32'(b));
        rdm(DR, 32'hff, 32'h35);
      end
    end
    // nine-bit character, then idle line
    wr(C1, 32'h50);
    rx(10'h1a5, 9, 1'b1, -1);
    rdm(C3, 32'h80, 32'h80);
    rdm(ST, 32'h20, 32'h20);
    rdm(DR, 32'hff, 32'ha5);
    wr(C2, 32'h14);
    repeat (12 * 16) @(posedge mclk);
    chk({31'h0, rx_irq}, 32'h1);
    rdm(ST, 32'h10, 32'h10);
    // debug break protects flags unless clearing is allowed
    wr(C2, 32'h04);
    rx(10'h077, 8, 1'b1, -1);
    wr(SY, 32'h02);
    rdm(ST, 32'h00, 32'h00);
    rdm(DR, 32'h00, 32'h00);
    rdm(ST, 32'h20, 32'h20);
    wr(SY, 32'h03);
    rdm(DR, 32'h00, 32'h00);
    wr(SY, 32'h00);
    rdm(ST, 32'h20, 32'h00);
    // disable sets the transmit flags; unmapped access refused
    wr(C1, 32'h00);
    rdm(ST, 32'hc0, 32'hc0);
    chk({31'h0, tx_irq}, 32'h0);
    apb(1'b0, 12'h0fc, 32'h0, q);
    chk({31'h0, perr}, 32'h1);
    // enable the module, the receiver and its request
    wr(C1, 32'h40);
    wr(C2, 32'h24);
    // stop freezes the receiver; loopback cuts the receive pin off
    wr(SY, 32'h08);
    rx(10'h055, 8, 1'b1, -1);
    chk({31'h0, rx_irq}, 32'h0);
    wr(SY, 32'h00);
    rdm(ST, 32'h20, 32'h00);
    wr(C2, 32'h2c);
    wr(C1, 32'hc0);
    rx(10'h055, 8, 1'b1, -1);
    rdm(ST, 32'h20, 32'h00);
    // address mark in the top bit wakes the standby receiver
    wr(C1, 32'h48);
    wr(C2, 32'h26);
    rx(10'h081, 8, 1'b1, -1);
    rdm(C2, 32'h02, 32'h00);
    rdm(ST, 32'h20, 32'h20);
    rdm(DR, 32'hff, 32'h81);
    wr(SY, 32'h04);
    wr(C1, 32'h00);
    rdm(C1, 32'hff, 32'h00);
    rx(10'h066, 8, 1'b1, -1);
    chk({31'h0, rx_irq}, 32'h1);
    close_out();
  end
endmodule : tb
